/* hdl/fcedir_top.sv */
// Load encoder usage, direction, scaling and quadrature counting block
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none
`include "fcedir_consts.svh"

// Summary of operation
// [R1] Usage value 0 runs with no load encoder and ignores all load feedback.
// [R2] Usage 1 selects a serial load encoder that counts up for CCW motor rotation.
// [R3] Usage 3 selects a serial load encoder that counts down for CCW motor rotation.
// [R4] Usage 5 and 7 select a pulse load encoder, counting up and down for CCW rotation.
// [R5] Software never writes the reserved usage values 2, 4, 6 or 8.
// [R6] Motor direction follows the direction select bit; encoder direction follows both. The divided output and feedback count ignore the select bit.
// [R7] For a forward reference the divided pulse output has phase B leading phase A.
// [R8] Forward is the direction in which feedback counts up, reverse counts down.
// [R9] Serial counts per motor revolution span 4 to 1048576, default 32768, applied on restart.
// [R10] For a pulse encoder the per revolution count is entered already times four.
// [R11] The pre quadrature pulse count spans 100 to 1048576, default 1024, applied on restart.
// [R12] Software rounds a fractional per revolution count to an integer.
// [R13] Software picks usage by turning the motor CCW with select 0 and usage 1.
// [R14] The feedback counter counts in pulses of one encoder pitch each.
// [R15] Quadrature inputs are decoded at four counts per cycle by phase order.
module fcedir_top
  import fcedir_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Load encoder pins
  input wire logic load_phase_a,
  input wire logic load_phase_b,
  input wire logic serial_step,
  input wire logic serial_up,
  // Motor and divided pulse outputs
  output logic motor_ccw,
  output logic div_phase_a,
  output logic div_phase_b
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [3:0] pend_use;
  logic pend_dir;
  logic [20:0] pend_counts;
  logic [20:0] pend_pulses;
  logic [3:0] load_encoder_usage;
  logic rotation_direction_select;
  logic [20:0] load_counts_per_motor_rev;
  logic [20:0] load_pulses_pre_quadrature;
  logic ref_forward;
  logic ref_step;
  logic apply_req;
  logic [31:0] fb_count;
  logic [1:0] div_state;
  fcedir_src_t src;
  logic count_inverted;

  logic [1:0] qa_sync;
  logic [1:0] qb_sync;
  logic [1:0] ss_sync;
  logic [1:0] su_sync;
  logic qa_prev;
  logic qb_prev;
  logic ss_prev;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [20:0] wdata21;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign wdata21 = pwdata[20:0];
  assign addr_ok = (paddr == `FCEDIR_OFS_CFG) || (paddr == `FCEDIR_OFS_COUNTS) ||
                   (paddr == `FCEDIR_OFS_PULSES) || (paddr == `FCEDIR_OFS_APPLY) ||
                   (paddr == `FCEDIR_OFS_STATUS) || (paddr == `FCEDIR_OFS_FBCOUNT) ||
                   (paddr == `FCEDIR_OFS_REFCMD) || (paddr == `FCEDIR_OFS_ACTCNT) ||
                   (paddr == `FCEDIR_OFS_ACTPUL);

  // ---------------------------------------------------------------
  // Pending settings, taken from software, held until restart
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_use <= `FCEDIR_RST_USE;
      pend_dir <= `FCEDIR_RST_DIR;
      pend_counts <= `FCEDIR_RST_COUNTS;
      pend_pulses <= `FCEDIR_RST_PULSES;
    end else if (wr_en) begin
      if (paddr == `FCEDIR_OFS_CFG) begin
        pend_dir <= pwdata[`FCEDIR_CFG_DIR_BIT];
        pend_use <= pwdata[`FCEDIR_CFG_USE_LSB +: 4]; // Reserved codes decode as none [R5]
      end
      // Out of range values are clamped into the legal span [R9] [R10]
      if (paddr == `FCEDIR_OFS_COUNTS) begin
        if (pwdata > 32'(`FCEDIR_MAX_COUNT)) begin
          pend_counts <= `FCEDIR_MAX_COUNT;
        end else if (wdata21 < `FCEDIR_MIN_COUNTS) begin
          pend_counts <= `FCEDIR_MIN_COUNTS;
        end else begin
          pend_counts <= wdata21;
        end
      end
      if (paddr == `FCEDIR_OFS_PULSES) begin
        if (pwdata > 32'(`FCEDIR_MAX_COUNT)) begin
          pend_pulses <= `FCEDIR_MAX_COUNT;
        end else if (wdata21 < `FCEDIR_MIN_PULSES) begin
          pend_pulses <= `FCEDIR_MIN_PULSES; // [R11]
        end else begin
          pend_pulses <= wdata21;
        end
      end
    end
  end

  // Restart request pulse, one cycle after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apply_req <= 1'b0;
    end else begin
      apply_req <= wr_en && (paddr == `FCEDIR_OFS_APPLY) && pwdata[0];
    end
  end

  // Active settings, updated only at restart [R9] [R11]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_encoder_usage <= `FCEDIR_RST_USE;
      rotation_direction_select <= `FCEDIR_RST_DIR;
      load_counts_per_motor_rev <= `FCEDIR_RST_COUNTS;
      load_pulses_pre_quadrature <= `FCEDIR_RST_PULSES;
    end else if (apply_req) begin
      load_encoder_usage <= pend_use;
      rotation_direction_select <= pend_dir;
      load_counts_per_motor_rev <= pend_counts;
      load_pulses_pre_quadrature <= pend_pulses;
    end
  end

  // Reference direction and step command from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_forward <= 1'b1;
      ref_step <= 1'b0;
    end else begin
      ref_step <= wr_en && (paddr == `FCEDIR_OFS_REFCMD) && pwdata[1];
      if (wr_en && (paddr == `FCEDIR_OFS_REFCMD)) begin
        ref_forward <= pwdata[0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Usage decode
  // ---------------------------------------------------------------
  always_comb begin
    src = fcedir_src_none; // [R1]
    count_inverted = 1'b0;
    case (load_encoder_usage)
      4'h1: src = fcedir_src_serial; // [R2]
      4'h3: begin
        src = fcedir_src_serial; // [R3]
        count_inverted = 1'b1;
      end
      4'h5: src = fcedir_src_pulse; // [R4]
      4'h7: begin
        src = fcedir_src_pulse; // [R4]
        count_inverted = 1'b1;
      end
      default: src = fcedir_src_none; // Reserved codes run as no encoder
    endcase
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qa_sync <= 2'h0;
      qb_sync <= 2'h0;
      ss_sync <= 2'h0;
      su_sync <= 2'h0;
      qa_prev <= 1'b0;
      qb_prev <= 1'b0;
      ss_prev <= 1'b0;
    end else begin
      qa_sync <= {qa_sync[0], load_phase_a};
      qb_sync <= {qb_sync[0], load_phase_b};
      ss_sync <= {ss_sync[0], serial_step};
      su_sync <= {su_sync[0], serial_up};
      qa_prev <= qa_sync[1];
      qb_prev <= qb_sync[1];
      ss_prev <= ss_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Feedback counter
  // ---------------------------------------------------------------
  logic q_move;
  logic q_up;
  logic raw_move;
  logic raw_up;
  logic quad_move;

  // Any change of one phase is one count; A leading B counts up [R15]
  assign quad_move = (qa_sync[1] ^ qa_prev) ^ (qb_sync[1] ^ qb_prev);
  assign q_move = quad_move;
  assign q_up = qa_sync[1] ^ qb_prev;

  always_comb begin
    raw_move = 1'b0;
    raw_up = 1'b0;
    unique case (src)
      fcedir_src_serial: begin
        raw_move = ss_sync[1] & ~ss_prev;
        raw_up = su_sync[1];
      end
      fcedir_src_pulse: begin
        raw_move = q_move;
        raw_up = q_up;
      end
      fcedir_src_none: begin
        raw_move = 1'b0; // Load feedback ignored [R1]
        raw_up = 1'b0;
      end
    endcase
  end

  // One count per encoder pitch; forward counts up, reverse down [R8] [R14]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fb_count <= 32'h00000000;
    end else if (apply_req) begin
      fb_count <= 32'h00000000;
    end else if (raw_move) begin
      if (raw_up ^ count_inverted) begin // [R2] [R3] [R4]
        fb_count <= fb_count + 32'h00000001;
      end else begin
        fb_count <= fb_count - 32'h00000001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Motor direction and divided pulse outputs
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motor_ccw <= 1'b1;
    end else begin
      motor_ccw <= ref_forward ^ rotation_direction_select; // [R6]
    end
  end

  // Gray walk: forward makes B lead A whatever the direction select [R7]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_state <= 2'h0;
    end else if (ref_step) begin
      if (ref_forward) begin
        div_state <= div_state + 2'h1;
      end else begin
        div_state <= div_state - 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_phase_a <= 1'b0;
      div_phase_b <= 1'b0;
    end else begin
      div_phase_b <= div_state[1] ^ div_state[0];
      div_phase_a <= div_state[1];
    end
  end

  // ---------------------------------------------------------------
  // APB answer: zero wait, error on unmapped address
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      prdata <= 32'h00000000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `FCEDIR_OFS_CFG: prdata <= {24'h000000, pend_use, 3'h0, pend_dir};
          `FCEDIR_OFS_COUNTS: prdata <= {11'h000, pend_counts};
          `FCEDIR_OFS_PULSES: prdata <= {11'h000, pend_pulses};
          `FCEDIR_OFS_STATUS: prdata <= {16'h0000, load_encoder_usage, 3'h0,
                                         rotation_direction_select, 6'h00, src};
          `FCEDIR_OFS_FBCOUNT: prdata <= fb_count;
          `FCEDIR_OFS_REFCMD: prdata <= {31'h00000000, ref_forward};
          `FCEDIR_OFS_ACTCNT: prdata <= {11'h000, load_counts_per_motor_rev}; // [R9]
          `FCEDIR_OFS_ACTPUL: prdata <= {11'h000, load_pulses_pre_quadrature}; // [R11]
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/fcedir_consts.svh */
// Register offsets, field positions, reset values and limits for the load encoder block
`ifndef FCEDIR_CONSTS_SVH
`define FCEDIR_CONSTS_SVH
`define FCEDIR_OFS_CFG 12'h000
`define FCEDIR_OFS_COUNTS 12'h004
`define FCEDIR_OFS_PULSES 12'h008
`define FCEDIR_OFS_APPLY 12'h00c
`define FCEDIR_OFS_STATUS 12'h010
`define FCEDIR_OFS_FBCOUNT 12'h014
`define FCEDIR_OFS_REFCMD 12'h018
`define FCEDIR_OFS_ACTCNT 12'h01c
`define FCEDIR_OFS_ACTPUL 12'h020
`define FCEDIR_CFG_DIR_BIT 0
`define FCEDIR_CFG_USE_LSB 4
`define FCEDIR_RST_USE 4'h0
`define FCEDIR_RST_DIR 1'h0
`define FCEDIR_RST_COUNTS 21'h008000
`define FCEDIR_RST_PULSES 21'h000400
`define FCEDIR_MIN_COUNTS 21'h000004
`define FCEDIR_MIN_PULSES 21'h000064
`define FCEDIR_MAX_COUNT 21'h100000
`endif

/* hdl/fcedir_pkg.sv */
// Types for the load encoder direction and scaling block
`default_nettype none
package fcedir_pkg;
  typedef enum logic [1:0] {fcedir_src_none, fcedir_src_serial, fcedir_src_pulse} fcedir_src_t;
endpackage
`default_nettype wire

/* verification/fcedir_top_assertions.sv */
// Checker for bus timing and outputs of the load encoder block
`default_nettype none
module fcedir_top_assertions (
  // Bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Encoder and motor side
  input wire logic load_phase_a,
  input wire logic load_phase_b,
  input wire logic serial_step,
  input wire logic serial_up,
  input wire logic motor_ccw,
  input wire logic div_phase_a,
  input wire logic div_phase_b
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write access marker
  logic acc_wr;
  assign acc_wr = psel && penable && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_recent_wr;
    $past(acc_wr, 1) || $past(acc_wr, 2) || $past(acc_wr, 3) || $past(acc_wr, 4);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad rd");
  a_div_one_phase: assert property (!($changed(div_phase_a) && $changed(div_phase_b)))
    else $error("both phases moved");
  a_div_by_write: assert property ($changed({div_phase_a, div_phase_b}) |-> s_recent_wr)
    else $error("divided output moved alone");
  a_motor_by_write: assert property ($changed(motor_ccw) |-> s_recent_wr)
    else $error("motor direction moved alone");
endmodule
bind fcedir_top fcedir_top_assertions chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .load_phase_a, .load_phase_b, .serial_step, .serial_up,
  .motor_ccw, .div_phase_a, .div_phase_b);
`default_nettype wire

/* verification/fcedir_enc_model.sv */
// Behavioural load encoder with quadrature and serial step outputs
`default_nettype none
module fcedir_enc_model (
  // Clock, reset and move request
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic up,
  // Encoder pins
  output logic pha,
  output logic phb,
  output logic sstep,
  output logic sup
);
  logic [1:0] pos;
  // Quadrature position, A rises first when moving up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos <= 2'h0;
    end else if (step) begin
      pos <= up ? pos + 2'h1 : pos - 2'h1;
    end
  end
  assign pha = pos[0] ^ pos[1];
  assign phb = pos[1];
  // Serial pitch strobe and direction level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sstep <= 1'b0;
      sup <= 1'b0;
    end else begin
      sstep <= step;
      sup <= up;
    end
  end
endmodule
`default_nettype wire

/* verification/fcedir_top_tb_top.sv */
// Testbench for the load encoder direction and scaling block
`default_nettype none
`include "fcedir_consts.svh"
module fcedir_top_tb_top import fcedir_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, step = 0, up = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, load_phase_a, load_phase_b, serial_step, serial_up, motor_ccw;
  logic div_phase_a, div_phase_b, er;
  int error_cnt = 0, total_checks = 0;
  // Clock
  always #2 pclk = ~pclk;
  fcedir_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .load_phase_a, .load_phase_b, .serial_step, .serial_up, .motor_ccw, .div_phase_a,
    .div_phase_b);
  fcedir_enc_model enc_u (.clk(pclk), .rst_n(presetn), .step, .up, .pha(load_phase_a),
    .phb(load_phase_b), .sstep(serial_step), .sup(serial_up));
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[ERR] %0t no pready", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] w, input logic [31:0] e);
    apb(1'b1, a, w);
    rdc(a, e);
  endtask
  function automatic logic [31:0] exp_fb(input int u, input int n, input logic dn);
    if (u == 0) return 32'h0;
    return (dn ^ (u == 3 || u == 7)) ? 32'(-n) : 32'(n);
  endfunction
  function automatic logic [31:0] exp_st(input int u, input logic d);
    logic [1:0] src;
    src = (u == 0) ? fcedir_src_none : (u < 5) ? fcedir_src_serial : fcedir_src_pulse;
    return {16'h0, 4'(u), 3'h0, d, 6'h0, src};
  endfunction
  // Watchdog cuts a hang short
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    int codes[5] = '{0, 1, 3, 5, 7}; // reserved values never loaded
    logic [1:0] divs[4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    int n, u;
    logic d, dn;
    logic [31:0] v, w;
    void'($urandom(89));
    tick(20);
    presetn <= 1'b1;
    rdc(`FCEDIR_OFS_CFG, 32'h0);
    rdc(`FCEDIR_OFS_COUNTS, 32'h8000);
    rdc(`FCEDIR_OFS_PULSES, 32'h400);
    rdc(`FCEDIR_OFS_STATUS, exp_st(0, 1'b0));
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1);
    wrc(`FCEDIR_OFS_COUNTS, 32'h3, 32'h4);
    wrc(`FCEDIR_OFS_COUNTS, 32'h100001, 32'h100000);
    wrc(`FCEDIR_OFS_PULSES, 32'h63, 32'h64);
    v = 32'h64 + $urandom % 32'hfff9d;
    wrc(`FCEDIR_OFS_PULSES, v, v);
    w = 32'h4 + $urandom % 32'hffffd;
    wrc(`FCEDIR_OFS_COUNTS, w, w);
    rdc(`FCEDIR_OFS_ACTCNT, 32'h8000);
    rdc(`FCEDIR_OFS_ACTPUL, 32'h400);
    foreach (codes[i]) begin
      for (int k = 0; k < 2; k++) begin
        u = codes[i];
        d = k[0];
        apb(1'b1, `FCEDIR_OFS_CFG, {24'h0, 4'(u), 3'h0, d});
        apb(1'b1, `FCEDIR_OFS_APPLY, 32'h1);
        tick(4);
        rdc(`FCEDIR_OFS_STATUS, exp_st(u, d));
        rdc(`FCEDIR_OFS_ACTCNT, w);
        rdc(`FCEDIR_OFS_ACTPUL, v);
        n = 1 + $urandom % 12;
        dn = 1'($urandom);
        up <= !dn;
        tick(3);
        repeat (n) begin
          step <= 1'b1;
          tick(1);
          step <= 1'b0;
          tick(1 + $urandom % 4);
        end
        tick(10);
        rdc(`FCEDIR_OFS_FBCOUNT, exp_fb(u, n, dn));
        for (int r = 0; r < 2; r++) begin
          apb(1'b1, `FCEDIR_OFS_REFCMD, 32'(r));
          tick(4);
          chk(32'(motor_ccw), 32'(r[0] ^ d));
        end
        foreach (divs[j]) begin
          apb(1'b1, `FCEDIR_OFS_REFCMD, 32'h3);
          tick(4);
          chk({30'h0, div_phase_a, div_phase_b}, {30'h0, divs[j]});
        end
        // Reverse step walks back one state, then forward again
        apb(1'b1, `FCEDIR_OFS_REFCMD, 32'h2);
        tick(4);
        chk({30'h0, div_phase_a, div_phase_b}, {30'h0, divs[2]});
        apb(1'b1, `FCEDIR_OFS_REFCMD, 32'h3);
        tick(4);
        chk({30'h0, div_phase_a, div_phase_b}, {30'h0, divs[3]});
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
